// File: dv/scanner_sva.sv
module scanner_sva (
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        full_speed_mode,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic [36:0] tube_pin_i,
	input wire logic [36:0] tube_drive_output,
	input wire logic [36:0] tube_drive_oe,
	input wire logic        pulldown_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [39:0] lat_q;
	logic [36:0] lm;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// shadow of the port latches, the only drive allowed while blanked
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			lat_q <= '0;
		end else begin
			for (int g = 0; g < 5; g++) begin
				if (reg_wr && reg_addr == vfd_pkg::ADDR_LATCH_LO + 12'(g)) begin
					lat_q[8 * g +: 8] <= reg_wdata;
				end
			end
		end
	end
	assign lm = lat_q[36:0];
	AST_RST_QUIET: assert property (disable iff (1'b0) !nrst |=> tube_drive_output == '0 && reg_rdata == '0)
		else $error("outputs not cleared by reset");
	AST_OE_FOLLOWS: assert property (tube_drive_oe == tube_drive_output)
		else $error("enable differs from drive");
	AST_PULL_ON: assert property (pulldown_enable)
		else $error("pull-down released");
	AST_BLANK_DRIVE: assert property (!full_speed_mode [*3] |-> (tube_drive_output & ~(lm | $past(lm) | $past(lm, 2))) == '0)
		else $error("scan drive while not at full speed");
	AST_C2_TOP: assert property (reg_rd && reg_addr == vfd_pkg::ADDR_CTRL_TWO |=> !reg_rdata[7])
		else $error("control two top bit reads one");
	AST_UNMAPPED: assert property (reg_rd && reg_addr < vfd_pkg::ADDR_CTRL_ONE |=> reg_rdata == '0)
		else $error("unmapped read not zero");
	AST_STAT_BLANK: assert property (reg_rd && reg_addr == vfd_pkg::ADDR_STATUS && !full_speed_mode
		&& !$past(full_speed_mode) |=> reg_rdata[1:0] == 2'b01)
		else $error("status not blanked");
	AST_C2_BACK: assert property (reg_wr && reg_addr == vfd_pkg::ADDR_CTRL_TWO ##1 !reg_wr ##1 reg_rd
		&& reg_addr == vfd_pkg::ADDR_CTRL_TWO |=> reg_rdata == ($past(reg_wdata, 3) & vfd_pkg::C2_MASK))
		else $error("control two readback wrong");
endmodule

bind fluorescent_display_scanner scanner_sva sva_u (.clk_sys(clk_sys), .nrst(nrst),
	.full_speed_mode(full_speed_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .tube_pin_i(tube_pin_i), .tube_drive_output(tube_drive_output),
	.tube_drive_oe(tube_drive_oe), .pulldown_enable(pulldown_enable));

// File: dv/tb_fluorescent_display_scanner.sv
module tb_fluorescent_display_scanner;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BASE = 64;
	logic        clk_sys = 1'b0;
	logic        nrst = 1'b0;
	logic        fsm = 1'b1;
	logic [11:0] addr = '0;
	logic [7:0]  wdat = '0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  rdat;
	logic [36:0] pin;
	logic [36:0] drv;
	logic [36:0] oe;
	logic        pd;
	logic [36:0] ext = '0;
	logic [39:0] pat[3];
	int          error_cnt = 0;
	int          check_count = 0;
	int          cyc = 0;

	always #25 clk_sys = ~clk_sys;

	fluorescent_display_scanner #(.DISP_BASE_CYC(BASE)) dut_u (.clk_sys(clk_sys), .nrst(nrst),
		.full_speed_mode(fsm), .reg_addr(addr), .reg_wdata(wdat), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdat), .tube_pin_i(pin), .tube_drive_output(drv), .tube_drive_oe(oe),
		.pulldown_enable(pd));
	tube_model tube_u (.drv(drv), .oe(oe), .pd_en(pd), .ext_hi(ext), .pin(pin));

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// guard against a hang, far above the ~1400 cycles the sequence takes
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 6000) begin
			error_cnt++;
			give_verdict();
		end
	end

	task automatic wreg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdat <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rchk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 chk(rdat & m, e);
	endtask

	// reprogram under blanking, restart, then follow slot order and lit time
	task automatic run(input logic [2:0] brightness_step_field, input logic [7:0] c1);
		logic [36:0] last;
		int          idx;
		int          n;
		int          len;
		last = '0;
		idx = -1;
		n = 0;
		len = BASE << c1[6:5]; // slot time doubles per select step
		wreg(12'hF70, 8'h80 | c1);
		wreg(12'hF71, {1'b0, brightness_step_field, 4'h2});
		wreg(12'hF70, c1);
		rchk(12'hF72, 8'h03, 8'h02);
		for (int i = 0; i < 20 + 4 * len; i++) begin
			@(posedge clk_sys);
			#1;
			if (i >= 20 && i < 20 + 3 * len && drv != '0)
				n++;
			if (drv != '0 && drv != last) begin
				idx = (idx + 1) % 3;
				chk(drv, pat[idx][36:0] & {c1[4:0], 32'hFFFF_FFFF});
			end
			last = drv;
		end
		chk(n, 3 * ((len / 8) * (brightness_step_field + 1) - 6));
	endtask

	initial begin
		logic [7:0] b;
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		#1 chk(drv, '0);
		rchk(12'hF70, 8'hFF, 8'h80);
		rchk(12'hF72, 8'hFF, 8'h01);
		rchk(12'h100, 8'hFF, 8'h00);
		wreg(12'hF71, 8'hFF);
		rchk(12'hF71, 8'hFF, 8'h7F);
		// three slots, one digit bit in slots 0 and 1; outputs 32 and 33 scanned as grids, both in slot 2
		// last column kept to bits 1..0, every other bit of every used byte left zero
		for (int s = 0; s < 3; s++) begin
			pat[s] = '0;
			for (int c = 0; c < 5; c++) begin
				b = (c == 4) ? 8'(s + 1) : 8'h01 << ((s + c) % 8);
				pat[s][8 * c +: 8] = b;
				wreg(12'hF80 + 12'(16 * c + s), b);
			end
		end
		rchk(12'hF91, 8'hFF, 8'h04);
		run(3'h7, 8'h1F);
		run(3'h0, 8'h00);
		run(3'h3, 8'h33);
		@(posedge clk_sys);
		fsm <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 chk(drv, '0);
		rchk(12'hF72, 8'h03, 8'h01);
		@(posedge clk_sys);
		fsm <= 1'b1;
		repeat (200) @(posedge clk_sys);
		#1 chk(drv, '0);
		wreg(12'hF73, 8'h5A);
		repeat (6) @(posedge clk_sys);
		#1 chk(drv[7:0], 8'h5A);
		rchk(12'hF73, 8'hFF, 8'h5A);
		wreg(12'hF73, 8'h00);
		ext <= 37'h3C;
		repeat (6) @(posedge clk_sys);
		rchk(12'hF73, 8'hFF, 8'h3C);
		give_verdict();
	end
endmodule

// File: dv/tube_model.sv
// tube electrodes: source open drain pins with pull-down to the tube supply
module tube_model (
	input  wire logic [36:0] drv,
	input  wire logic [36:0] oe,
	input  wire logic        pd_en,
	input  wire logic [36:0] ext_hi,
	output logic      [36:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// a released pin sinks to the pull-down; without it the level is not trustworthy
	assign pin = (drv & oe) | ext_hi | (pd_en ? '0 : ~drv);
endmodule

// File: rtl/display_buffer_mem.sv
// 80-byte display buffer, one write port and two registered read ports
module display_buffer_mem (
	input  wire logic       clk_sys,
	input  wire logic       wr_en,
	input  wire logic [6:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic [6:0] rd_a_addr,
	output logic      [7:0] rd_a_data,
	input  wire logic [6:0] rd_b_addr,
	output logic      [7:0] rd_b_data
);

	logic [7:0] mem [0:vfd_pkg::BUF_DEPTH-1];

	// contents are software's to set up; no reset so it maps onto plain ram
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// port a serves the register port, port b the scanner
	always_ff @(posedge clk_sys) begin
		rd_a_data <= mem[rd_a_addr];
		rd_b_data <= mem[rd_b_addr];
	end

endmodule

// File: rtl/fluorescent_display_scanner.sv
// Behaviour
// R1: leaving full speed blanks the scanner and zeroes all segment and digit drive
// R2: while blanked the tube pins act as port outputs with pull-down
// R3: control one holds slot time and output select; control two brightness and slot count
// R4: software keeps blanking set while programming timing, selection, brightness, count
// R5: software sets slot count to the number of digits of the tube
// R6: buffer at F80..FCF is copied to the outputs continuously, without software help
// R7: each buffer bit drives one output, a one lights it in its slot
// R8: buffer region holds display data only, not general storage
// R9: slot n reads byte n of five columns; last column feeds outputs 32..36
// R10: software writes zero into bits 7..5 of the last column
// R11: clearing blanking starts scanning and driving
// R12: conventional tube uses one digit per slot in sequence
// R13: grid-scan tube may light several grids in one slot
// R14: port output latches reset to zero
// R15: software keeps latch zero on pins driven by the scanner
// R16: shared pins used as port keep their buffer bits zero
// R17: each last-group pin chosen as display or port by its select bit
// R18: software clears the latch before using a pin as input
// R19: unused pins get latch and buffer bits cleared
// R20: a status register reports the operating state
// R21: eight brightness steps set the lit portion of each slot
// R22: one to sixteen slots, numbered zero to fifteen
// R23: output select sits in bits 4..0 of control one
// R24: thirty-seven drive outputs numbered zero to thirty-six
// R25: slots advance cyclically, each one slot time long, wrapping after the last
//
// Local design decisions: the register addresses and strobed register access.
module fluorescent_display_scanner #(
	parameter int DISP_BASE_CYC = vfd_pkg::DISP_BASE_CYC
) (
	input  wire logic                         clk_sys,
	input  wire logic                         nrst,
	input  wire logic                         full_speed_mode,
	input  wire logic [11:0]                  reg_addr,
	input  wire logic [7:0]                   reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [7:0]                   reg_rdata,
	input  wire logic [vfd_pkg::NUM_OUT-1:0]  tube_pin_i,
	output logic      [vfd_pkg::NUM_OUT-1:0]  tube_drive_output,
	output logic      [vfd_pkg::NUM_OUT-1:0]  tube_drive_oe,
	output logic                              pulldown_enable
);

	// short alias for the output count, used in the output-wide vectors below
	localparam int NO = vfd_pkg::NUM_OUT;

	// register state
	logic [7:0]          ctrl1_q;
	logic [7:0]          ctrl2_q;
	logic [NO-1:0]       latch_q;
	vfd_pkg::scan_state_t state_q;
	logic [3:0]          slot_q;
	logic [13:0]         cnt_q;
	logic [NO-1:0]       shadow_q;
	logic [NO-1:0]       drive_q;
	logic                lit_q;
	logic [NO-1:0]       sync1_q;
	logic [NO-1:0]       sync2_q;
	logic [NO-1:0]       sync3_q;
	logic [NO-1:0]       pin_q;
	logic [7:0]          rdata_q;
	logic                rd_mem_q;
	logic [7:0]          status_byte;
	logic [7:0]          pin_grp [0:vfd_pkg::NUM_COL-1];

	// decoded fields
	logic                blank_bit;
	logic [1:0]          time_sel;
	logic [4:0]          out_sel;
	logic [2:0]          brightness_step_field;
	logic [3:0]          last_slot;
	logic [13:0]         slot_len;
	logic [16:0]         on_len;
	logic                slot_end;
	logic [NO-1:0]       disp_mask;
	logic                scan_on;
	logic                fetch_cap;
	logic                hit_latch;
	logic [2:0]          latch_idx;

	// bus decode
	logic                hit_buf;
	logic [6:0]          buf_idx;
	logic [6:0]          scan_idx;
	logic [7:0]          mem_a_data;
	logic [7:0]          mem_b_data;
	logic [2:0]          col_w;
	logic [2:0]          col_r;

	// control fields; control two bit 7 is never stored so it always reads zero
	assign blank_bit = ctrl1_q[vfd_pkg::C1_BLANK_BIT];
	assign time_sel  = ctrl1_q[vfd_pkg::C1_TIME_MSB:vfd_pkg::C1_TIME_LSB]; // R3
	assign out_sel   = ctrl1_q[vfd_pkg::C1_SEL_MSB:vfd_pkg::C1_SEL_LSB]; // R23
	assign brightness_step_field       = ctrl2_q[vfd_pkg::C2_DIM_MSB:vfd_pkg::C2_DIM_LSB]; // R3
	assign last_slot = ctrl2_q[vfd_pkg::C2_CNT_MSB:vfd_pkg::C2_CNT_LSB]; // R22

	// slot time is base doubled per select step, base 2^10 up to 2^13 clocks
	assign slot_len  = 14'(DISP_BASE_CYC) << time_sel;
	// lit part of a slot in eighths: dim 0 lights 1/8, dim 7 the whole slot
	assign on_len    = 17'((17'(slot_len) >> vfd_pkg::DIM_SHIFT) * (17'(brightness_step_field) + 17'h00001)); // R21
	assign slot_end  = (cnt_q == slot_len - 14'h0001);

	// register port decode of the buffer window and of the five port latch bytes
	assign hit_buf   = (reg_addr >= vfd_pkg::ADDR_BUF_LO) && (reg_addr <= vfd_pkg::ADDR_BUF_HI); // R6
	assign buf_idx   = 7'(reg_addr - vfd_pkg::ADDR_BUF_LO);
	assign hit_latch = (reg_addr >= vfd_pkg::ADDR_LATCH_LO) && (reg_addr <= vfd_pkg::ADDR_LATCH_HI);
	assign latch_idx = 3'(reg_addr - vfd_pkg::ADDR_LATCH_LO);

	// outputs 0..31 always belong to the scanner; 32..36 per select bit
	assign disp_mask = {out_sel, 32'hFFFFFFFF}; // R17

	// software owns the blanking bit, but leaving full speed forces it set
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ctrl1_q <= vfd_pkg::C1_RESET;
		end else begin
			if (reg_wr && reg_addr == vfd_pkg::ADDR_CTRL_ONE) begin
				ctrl1_q <= reg_wdata;
			end
			if (!full_speed_mode) begin
				ctrl1_q[vfd_pkg::C1_BLANK_BIT] <= 1'b1; // R1
			end
		end
	end

	// brightness and slot count; software changes them only while blanked
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ctrl2_q <= vfd_pkg::C2_RESET;
		end else if (reg_wr && reg_addr == vfd_pkg::ADDR_CTRL_TWO) begin
			ctrl2_q <= reg_wdata & vfd_pkg::C2_MASK; // R3
		end
	end

	// port output latches, one byte per group, top group only 5 bits wide
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			latch_q <= '0; // R14
		end else if (reg_wr && hit_latch) begin
			case (latch_idx)
				3'h0: latch_q[7:0]   <= reg_wdata;
				3'h1: latch_q[15:8]  <= reg_wdata;
				3'h2: latch_q[23:16] <= reg_wdata;
				3'h3: latch_q[31:24] <= reg_wdata;
				default: latch_q[36:32] <= reg_wdata[4:0];
			endcase
		end
	end

	// scanner state: scan only with blanking clear and full speed
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state_q <= vfd_pkg::ST_BLANKED;
		end else begin
			case (state_q)
				vfd_pkg::ST_BLANKED: begin
					if (!blank_bit && full_speed_mode) begin
						state_q <= vfd_pkg::ST_SCANNING; // R11
					end
				end
				vfd_pkg::ST_SCANNING: begin
					if (blank_bit || !full_speed_mode) begin
						state_q <= vfd_pkg::ST_BLANKED; // R1
					end
				end
				default: state_q <= vfd_pkg::ST_BLANKED;
			endcase
		end
	end

	// one qualifier for every scan-side process keeps them from drifting apart
	assign scan_on = (state_q == vfd_pkg::ST_SCANNING);

	// slot timer; a fresh scan always starts at slot zero
	// a count lowered mid-scan takes effect at once: the slot wraps at the next slot end
	always_ff @(posedge clk_sys) begin
		if (!nrst || !scan_on) begin
			cnt_q  <= '0;
			slot_q <= '0;
		end else if (slot_end) begin
			cnt_q  <= '0;
			slot_q <= (slot_q >= last_slot) ? 4'h0 : slot_q + 4'h1; // R25
		end else begin
			cnt_q <= cnt_q + 14'h0001; // R25
		end
	end

	// fetch: column c of slot n sits at c*16+n, read in the first cycles of a slot
	assign col_r    = (cnt_q[3:0] < vfd_pkg::FETCH_CYC - 4'h1) ? cnt_q[2:0] : 3'h0;
	assign scan_idx = {col_r, slot_q}; // R9
	assign col_w    = 3'(cnt_q[3:0] - 4'h1);
	// capture lags each read by one clock, as the buffer read port is registered
	assign fetch_cap = scan_on && cnt_q[13:4] == 10'h000
			&& cnt_q[3:0] >= 4'h1 && cnt_q[3:0] < vfd_pkg::FETCH_CYC;

	// shadow holds the whole slot so the pins never see a half-fetched pattern
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			shadow_q <= '0;
		end else if (fetch_cap) begin
			case (col_w)
				3'h0: shadow_q[7:0]   <= mem_b_data; // R9
				3'h1: shadow_q[15:8]  <= mem_b_data;
				3'h2: shadow_q[23:16] <= mem_b_data;
				3'h3: shadow_q[31:24] <= mem_b_data;
				default: shadow_q[36:32] <= mem_b_data[vfd_pkg::LAST_COL_BITS-1:0]; // R10
			endcase
		end
	end

	// lit window after fetch; stale data never reaches the pins during a fetch
	// mode and blanking are tested directly so the drive drops in the same clock as the state
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			lit_q   <= 1'b0;
			drive_q <= '0;
		end else if (scan_on && full_speed_mode && !blank_bit
				&& cnt_q >= 14'(vfd_pkg::FETCH_CYC) && 17'(cnt_q) < on_len) begin
			lit_q   <= 1'b1;
			drive_q <= shadow_q & disp_mask; // R7 R24
		end else begin
			lit_q   <= 1'b0;
			drive_q <= '0; // R1
		end
	end

	// source open drain: a one drives high, a zero leaves the pin to pull-down
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			tube_drive_output <= '0;
		end else begin
			tube_drive_output <= drive_q | latch_q; // R2 R17
		end
	end

	// enable only where a one is driven; the pull-down is never switched off
	assign tube_drive_oe   = tube_drive_output;
	assign pulldown_enable = 1'b1; // R2

	// pin inputs cross in from outside; a change counts once stages two and three agree
	// while the two stages disagree the filtered level holds, so one-clock glitches never show
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			pin_q   <= '0;
		end else begin
			sync1_q <= tube_pin_i;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pin_q   <= (sync2_q & sync3_q) | (pin_q & (sync2_q ^ sync3_q));
		end
	end

	// buffer: port a for the register port, port b for the scanner fetch
	display_buffer_mem u_buf (
		.clk_sys   (clk_sys),
		.wr_en     (reg_wr && hit_buf), // R6 R8
		.wr_addr   (buf_idx),
		.wr_data   (reg_wdata),
		.rd_a_addr (buf_idx),
		.rd_a_data (mem_a_data),
		.rd_b_addr (scan_idx),
		.rd_b_data (mem_b_data)
	);

	// filtered pin levels regrouped as port bytes; the top group has five pins only
	for (genvar g = 0; g < vfd_pkg::NUM_COL; g++) begin : g_pin_grp
		if (g == vfd_pkg::NUM_COL - 1) begin : g_top
			assign pin_grp[g] = {3'h0, pin_q[8 * g +: vfd_pkg::LAST_COL_BITS]};
		end else begin : g_full
			assign pin_grp[g] = pin_q[8 * g +: 8];
		end
	end

	// status byte kept apart from the read mux; slot field shows the slot being driven
	always_comb begin
		status_byte                         = '0;
		status_byte[vfd_pkg::ST_BLANK_BIT]  = (state_q == vfd_pkg::ST_BLANKED); // R20
		status_byte[vfd_pkg::ST_SCAN_BIT]   = scan_on;
		status_byte[vfd_pkg::ST_LIT_BIT]    = lit_q;
		status_byte[7:vfd_pkg::ST_SLOT_LSB] = slot_q;
	end

	// register reads answer in the next cycle; unmapped addresses read zero
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rdata_q  <= '0;
			rd_mem_q <= 1'b0;
		end else begin
			rd_mem_q <= reg_rd && hit_buf;
			rdata_q  <= '0;
			if (reg_rd) begin
				case (reg_addr)
					vfd_pkg::ADDR_CTRL_ONE: rdata_q <= ctrl1_q;
					vfd_pkg::ADDR_CTRL_TWO: rdata_q <= ctrl2_q;
					vfd_pkg::ADDR_STATUS:   rdata_q <= status_byte; // R20
					default:                rdata_q <= hit_latch ? pin_grp[latch_idx] : 8'h00;
				endcase
			end
		end
	end

	// buffer reads come straight from the memory's own output register
	assign reg_rdata = rd_mem_q ? mem_a_data : rdata_q;

endmodule

// File: rtl/vfd_pkg.sv
package vfd_pkg;

	// register map, byte addresses on the 12-bit register port
	localparam logic [11:0] ADDR_CTRL_ONE  = 12'hF70;
	localparam logic [11:0] ADDR_CTRL_TWO  = 12'hF71;
	localparam logic [11:0] ADDR_STATUS    = 12'hF72;
	localparam logic [11:0] ADDR_LATCH_LO  = 12'hF73; // five port latch bytes F73..F77
	localparam logic [11:0] ADDR_LATCH_HI  = 12'hF77;
	localparam logic [11:0] ADDR_BUF_LO    = 12'hF80;
	localparam logic [11:0] ADDR_BUF_HI    = 12'hFCF;

	// geometry
	localparam int          NUM_OUT        = 37;
	localparam int          NUM_COL        = 5;
	localparam int          NUM_SLOT       = 16;
	localparam int          BUF_DEPTH      = 80;
	localparam int          LAST_COL_BITS  = 5;

	// display_control_one fields
	localparam int          C1_BLANK_BIT   = 7;
	localparam int          C1_TIME_MSB    = 6;
	localparam int          C1_TIME_LSB    = 5;
	localparam int          C1_SEL_MSB     = 4;
	localparam int          C1_SEL_LSB     = 0;
	localparam logic [7:0]  C1_RESET       = 8'h80;

	// display_control_two fields
	localparam int          C2_DIM_MSB     = 6;
	localparam int          C2_DIM_LSB     = 4;
	localparam int          C2_CNT_MSB     = 3;
	localparam int          C2_CNT_LSB     = 0;
	localparam logic [7:0]  C2_RESET       = 8'h00;
	localparam logic [7:0]  C2_MASK        = 8'h7F;

	// status fields
	localparam int          ST_BLANK_BIT   = 0;
	localparam int          ST_SCAN_BIT    = 1;
	localparam int          ST_LIT_BIT     = 2;
	localparam int          ST_SLOT_LSB    = 4;

	// timing: shortest slot is 2^10 system clocks, brightness in eighths
	localparam int          DISP_BASE_CYC  = 1024;
	localparam int          DIM_SHIFT      = 3;
	localparam logic [3:0]  FETCH_CYC      = 4'h6; // five column reads plus read latency

	typedef enum logic [1:0] {
		ST_BLANKED = 2'b01,
		ST_SCANNING = 2'b10
	} scan_state_t;

endpackage
